/* File: bench/pwrirq_assertions.sv */
/* checker for pwrirq_regs: bus handshakes, sticky irq, indirect request end.
   assumes a bind on the top module and the single aclk domain. */
`timescale 1ns/1ps
module pwrirq_assertions #(parameter int UPDATE_CYCLES = 8) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic ind_req,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // two cycles of slack past one update period
    localparam int IND_MAX = UPDATE_CYCLES + 2;
    sequence s_aw_taken; s_axi_awvalid && s_axi_awready; endsequence
    sequence s_w_taken; s_axi_wvalid && s_axi_wready; endsequence
    a_write_answer: assert property (s_aw_taken ##0 s_w_taken |-> ##2 s_axi_bvalid)
        else $error("write response missing after address and data");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels ready while a response is open");
    a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing after address taken");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready while data is open");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data above the byte lane");
    a_irq_sticky: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("irq dropped without a register write");
    a_ind_ends: assert property ($rose(ind_req) |-> ##[1:IND_MAX] !ind_req)
        else $error("indirect request outlived one update period");
endmodule : pwrirq_assertions

/* File: bench/pwrirq_host.sv */
/* host model: axi4-lite master standing in for host software.
   assumes wr and rd are called one at a time from one process. */
`timescale 1ns/1ps
module pwrirq_host (
    input wire logic aclk,
    output logic [11:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [11:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    output logic hung
);
    // idle bus at time zero; byte lanes always all enabled
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
        s_axi_wstrb = 4'hF;
    end
    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        n = 0;
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            n++;
            // released lines flip so a stale value cannot pass
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end while (!s_axi_bvalid && n < 200);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
        if (n >= 200) hung <= 1'b1;
    endtask : wr
    // one read; rready held from the start until data is seen
    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        n = 0;
        s_axi_araddr <= {2'h0, idx, 2'h0};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~s_axi_araddr;
            end
        end while (!s_axi_rvalid && n < 200);
        s_axi_rready <= 1'b0;
        {d, r} = {s_axi_rdata, s_axi_rresp};
        if (n >= 200) hung <= 1'b1;
    endtask : rd
endmodule : pwrirq_host

/* File: bench/testbench.sv */
/* bench for pwrirq_regs: host model on the bus, events and auto levels here.
   assumes package, checker and host model are compiled first. */
`timescale 1ns/1ps
module testbench;
    import pwrirq_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] timer_evt, alarm_evt;
    logic loop_change_evt, ring_trip_evt, adc_auto_on, dac_auto_on, transamp_auto_on;
    logic adc_pwr, dac_pwr, transamp_pwr, ind_req, irq, hung;
    logic [7:0] pt, pl, pi, et, el, ei, mt, ml; // expected pending, enables, clear masks
    int err_total, samples_checked, seed;
    localparam int UPD = 8; // short update period keeps the run brief
    pwrirq_regs #(.UPDATE_CYCLES(UPD)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_evt, .alarm_evt, .loop_change_evt,
        .ring_trip_evt, .adc_auto_on, .dac_auto_on, .transamp_auto_on, .adc_pwr, .dac_pwr,
        .transamp_pwr, .ind_req, .irq);
    pwrirq_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .hung);
    // 25 MHz clock
    initial begin aclk = 1'b0; forever #20 aclk = ~aclk; end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // mapped places answer okay, everything else slave error
    function automatic logic [1:0] resp_of(input logic [7:0] a);
        return (a inside {PWRIRQ_IDX_POWER_OVR, [PWRIRQ_IDX_TIMER_PEND:PWRIRQ_IDX_IND_EN],
            PWRIRQ_IDX_AUTO_PWR, PWRIRQ_IDX_IND_REQ}) ? PWRIRQ_RESP_OKAY : PWRIRQ_RESP_SLVERR;
    endfunction : resp_of
    function automatic logic exp_irq();
        return |(pt & et) || |(pl & el) || |(pi & ei & PWRIRQ_IND_MASK);
    endfunction : exp_irq
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        host.wr(a, d, r);
        chk({30'h0, r}, {30'h0, resp_of(a)});
    endtask : wr
    // top two data bits carry the response instead; the checker guards them
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        chk({r, d[29:0]}, {resp_of(a), 22'h0, e});
    endtask : rd
    // one-cycle event pulses; bit order timer, alarms, loop change, ring trip
    task automatic fire(input logic [13:0] v);
        @(posedge aclk);
        {ring_trip_evt, loop_change_evt, alarm_evt, timer_evt} <= v;
        @(posedge aclk);
        {ring_trip_evt, loop_change_evt, alarm_evt, timer_evt} <= 14'h0;
        pt = pt | {2'h0, v[5:0]};
        pl = pl | {v[11:6], v[12], v[13]};
    endtask : fire
    task automatic settle();
        repeat (2) @(posedge aclk);
        @(negedge aclk);
    endtask : settle
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    // bus hang and overall run limit
    always @(posedge aclk) if (hung === 1'b1) begin err_total++; stop_test(); end
    initial begin repeat (100000) @(posedge aclk); err_total++; stop_test(); end
    initial begin
        {seed, err_total, samples_checked} = {32'd26624, 64'd0};
        {aresetn, timer_evt, alarm_evt, loop_change_evt, ring_trip_evt} = '0;
        {adc_auto_on, dac_auto_on, transamp_auto_on, pt, pl, pi, et, el, ei} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, unmapped holes at 0x10 and 0x11 included
        for (int a = 8'h0F; a <= 8'h18; a++) rd(8'(a), 8'h00);
        wr(8'h40, 8'hFF); // unmapped write refused
        // every override value, autos set to random levels twice under each
        for (int v = 0; v < 64; v++) begin
            wr(PWRIRQ_IDX_POWER_OVR, 8'(v | 8'hC0));
            repeat (2) begin
                @(posedge aclk);
                {adc_auto_on, dac_auto_on, transamp_auto_on} <= 3'($random(seed));
                settle();
                chk({adc_pwr, dac_pwr, transamp_pwr}, {v[5] ? v[4] : adc_auto_on, v[3] ? v[2]
                    : dac_auto_on, v[1] ? v[0] : transamp_auto_on});
            end
            rd(PWRIRQ_IDX_POWER_OVR, 8'(v));
            rd(PWRIRQ_IDX_AUTO_PWR, {5'h0, adc_auto_on, dac_auto_on, transamp_auto_on});
        end
        wr(PWRIRQ_IDX_AUTO_PWR, 8'hFF); // read-only place, no effect
        // events, enables and write-one clears; first round clears none, second all, the rest random masks
        for (int k = 0; k < 40; k++) begin
            {et, el, ei} = 24'($random(seed));
            wr(PWRIRQ_IDX_TIMER_EN, et);
            wr(PWRIRQ_IDX_LINE_EN, el);
            wr(PWRIRQ_IDX_IND_EN, ei);
            ei = ei & PWRIRQ_IND_EN_MASK;
            rd(PWRIRQ_IDX_IND_EN, ei);
            fire(14'($random(seed)));
            settle();
            chk({31'h0, irq}, {31'h0, exp_irq()});
            rd(PWRIRQ_IDX_TIMER_PEND, pt);
            rd(PWRIRQ_IDX_LINE_PEND, pl);
            mt = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
            ml = (k < 2) ? mt : 8'($random(seed));
            wr(PWRIRQ_IDX_TIMER_PEND, mt);
            wr(PWRIRQ_IDX_LINE_PEND, ml);
            {pt, pl} = {pt & ~mt, pl & ~ml};
            settle();
            chk({31'h0, irq}, {31'h0, exp_irq()});
            rd(PWRIRQ_IDX_TIMER_PEND, pt);
            rd(PWRIRQ_IDX_LINE_PEND, pl);
        end
        // indirect request completes at the next update and stays pending
        wr(PWRIRQ_IDX_TIMER_PEND, 8'hFF);
        wr(PWRIRQ_IDX_LINE_PEND, 8'hFF);
        {pt, pl, ei} = {16'h0, PWRIRQ_IND_MASK};
        wr(PWRIRQ_IDX_IND_EN, ei);
        wr(PWRIRQ_IDX_IND_REQ, 8'h01);
        for (int n = 0; n < 4 * UPD && ind_req !== 1'b0; n++) @(posedge aclk);
        pi = PWRIRQ_IND_MASK;
        settle();
        chk({30'h0, ind_req, irq}, {31'h0, exp_irq()});
        repeat (3 * UPD) @(posedge aclk);
        rd(PWRIRQ_IDX_IND_PEND, pi);
        rd(PWRIRQ_IDX_IND_REQ, 8'h00);
        wr(PWRIRQ_IDX_IND_PEND, 8'hFF);
        pi = 8'h00;
        settle();
        chk({31'h0, irq}, 32'h0);
        rd(PWRIRQ_IDX_IND_PEND, pi);
        stop_test();
    end
endmodule : testbench
bind pwrirq_regs pwrirq_assertions #(.UPDATE_CYCLES(UPDATE_CYCLES)) chk_i (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .ind_req, .irq);

/* File: core/pwrirq_pkg.sv */
/*
 * package for the analog power override and interrupt pending register bank:
 * register offsets, field positions, reset values and the update-rate timing.
 * assumes a single 25 MHz system clock and byte-wide registers in 32-bit words.
 */
package pwrirq_pkg;
    // printed offsets are not all multiples of four, so they are indices
    localparam logic [7:0] PWRIRQ_IDX_POWER_OVR = 8'h0F;
    localparam logic [7:0] PWRIRQ_IDX_TIMER_PEND = 8'h12;
    localparam logic [7:0] PWRIRQ_IDX_LINE_PEND = 8'h13;
    localparam logic [7:0] PWRIRQ_IDX_IND_PEND = 8'h14;
    localparam logic [7:0] PWRIRQ_IDX_TIMER_EN = 8'h15;
    localparam logic [7:0] PWRIRQ_IDX_LINE_EN = 8'h16;
    localparam logic [7:0] PWRIRQ_IDX_IND_EN = 8'h17;
    localparam logic [7:0] PWRIRQ_IDX_AUTO_PWR = 8'h30;
    localparam logic [7:0] PWRIRQ_IDX_IND_REQ = 8'h31;
    // power override field positions
    localparam int PWRIRQ_ADC_MANUAL_BIT = 5;
    localparam int PWRIRQ_ADC_ON_BIT = 4;
    localparam int PWRIRQ_DAC_MANUAL_BIT = 3;
    localparam int PWRIRQ_DAC_ON_BIT = 2;
    localparam int PWRIRQ_TRANSAMP_MANUAL_BIT = 1;
    localparam int PWRIRQ_TRANSAMP_ON_BIT = 0;
    // implemented bit masks per register
    localparam logic [7:0] PWRIRQ_POWER_OVR_MASK = 8'h3F;
    localparam logic [7:0] PWRIRQ_TIMER_MASK = 8'h3F;
    localparam logic [7:0] PWRIRQ_LINE_MASK = 8'hFF;
    localparam logic [7:0] PWRIRQ_IND_MASK = 8'h02;
    localparam logic [7:0] PWRIRQ_IND_EN_MASK = 8'h03;
    localparam int PWRIRQ_IND_DONE_BIT = 1;
    // reset values
    localparam logic [7:0] PWRIRQ_POWER_OVR_RST = 8'h00;
    localparam logic [7:0] PWRIRQ_PEND_RST = 8'h00;
    localparam logic [7:0] PWRIRQ_EN_RST = 8'h00;
    // internal update rate for indirect access completion
    localparam int PWRIRQ_CLK_HZ = 25000000;
    localparam int PWRIRQ_UPDATE_HZ = 16000;
    localparam int PWRIRQ_UPDATE_CYCLES = PWRIRQ_CLK_HZ / PWRIRQ_UPDATE_HZ;
    // axi response codes
    localparam logic [1:0] PWRIRQ_RESP_OKAY = 2'h0;
    localparam logic [1:0] PWRIRQ_RESP_SLVERR = 2'h2;
endpackage : pwrirq_pkg

/* File: core/pwrirq_regs.sv */
/*
 * analog power override and interrupt pending register bank, axi4-lite slave.
 * power selects for the converters and the amplifier, three sticky
 * pending registers with enables, and an indirect request word.
 * assumes event inputs are single-cycle pulses on aclk from on-chip logic.
 * assumes the automatic power levels come from a sequencer on aclk.
 * assumes at most one write and one read in flight.
 * only byte lane 0 is stored; upper lanes read zero.
 * unmapped or unaligned places answer slave error.
 * reset is synchronous, active low; all registers clear.
 */
// Operation
// - adc manual select bit 5
// - adc on bit 4 acts only manual
// - dac manual select bit 3
// - dac on bit 2 acts only manual
// - amplifier manual select bit 1
// - amplifier on bit 0 acts only manual
// - ringing inactive/active pending bits 5,4
// - oscillator two pending bits 3,2
// - oscillator one pending bits 1,0
// - write one clears pending bit
// - timer pending reads zero after reset
// - six power alarm pending bits 7:2
// - loop change pending bit 1
// - ring trip pending bit 0
// - indirect done pending bit 1, sticky
// - each pending bit has enable mask
// - indirect access completes at 16 kHz tick

`timescale 1ns/1ps
module pwrirq_regs #(
    parameter int UPDATE_CYCLES = pwrirq_pkg::PWRIRQ_UPDATE_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // event pulses
    input wire logic [5:0] timer_evt,
    input wire logic [5:0] alarm_evt,
    input wire logic loop_change_evt,
    input wire logic ring_trip_evt,
    // sequencer levels
    input wire logic adc_auto_on,
    input wire logic dac_auto_on,
    input wire logic transamp_auto_on,
    // analog power controls
    output logic adc_pwr,
    output logic dac_pwr,
    output logic transamp_pwr,
    // indirect engine and interrupt
    output logic ind_req,
    output logic irq
);
    import pwrirq_pkg::*;

    // limitations:
    // events are not counted; two before a clear look like one
    // power outputs lag their select by one cycle
    // the tick runs free, so waits vary up to one period

    // register state
    logic [7:0] power_ovr_q; // analog_power_override
    logic [7:0] timer_pend_q; // timer_irq_pending
    logic [7:0] line_pend_q; // line_irq_pending
    logic [7:0] ind_pend_q; // indirect_done_pending

    // enables, same layout as pending
    logic [7:0] timer_en_q;
    logic [7:0] line_en_q;
    logic [7:0] ind_en_q;

    logic ind_busy_q; // indirect request waiting for tick
    logic [15:0] tick_cnt_q; // update-rate divider

    // bus handshake state
    logic [11:0] awaddr_q; // held until data arrives
    logic aw_have_q; // address taken
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_have_q; // data taken

    // map a byte address to a register index, valid only if aligned
    function automatic logic [7:0] pwrirq_index(input logic [11:0] addr);
        pwrirq_index = addr[9:2];
    endfunction : pwrirq_index

    // update tick: one-cycle enable at 16 kHz
    // period is exactly UPDATE_CYCLES
    wire tick_hit = (tick_cnt_q == 16'(UPDATE_CYCLES - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_q <= 16'h0000;
        end else if (tick_hit) begin
            // wrap on the tick
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    // write path: address and data may come in either order
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    // only lane 0 is stored
    wire [7:0] wr_idx = pwrirq_index(awaddr_q);
    wire wr_lane0 = wr_fire && wstrb_q[0];
    wire [7:0] wbyte = wdata_q[7:0];

    // one strobe per register
    wire wr_hit_ovr = wr_lane0 && (wr_idx == PWRIRQ_IDX_POWER_OVR);
    wire wr_hit_tp = wr_lane0 && (wr_idx == PWRIRQ_IDX_TIMER_PEND);
    wire wr_hit_lp = wr_lane0 && (wr_idx == PWRIRQ_IDX_LINE_PEND);
    wire wr_hit_ip = wr_lane0 && (wr_idx == PWRIRQ_IDX_IND_PEND);
    wire wr_hit_te = wr_lane0 && (wr_idx == PWRIRQ_IDX_TIMER_EN);
    wire wr_hit_le = wr_lane0 && (wr_idx == PWRIRQ_IDX_LINE_EN);
    wire wr_hit_ie = wr_lane0 && (wr_idx == PWRIRQ_IDX_IND_EN);
    wire wr_hit_req = wr_lane0 && (wr_idx == PWRIRQ_IDX_IND_REQ);
    // decode of whether a write address is mapped
    wire wr_mapped = (wr_idx == PWRIRQ_IDX_POWER_OVR) || (wr_idx == PWRIRQ_IDX_TIMER_PEND)
                  || (wr_idx == PWRIRQ_IDX_LINE_PEND) || (wr_idx == PWRIRQ_IDX_IND_PEND)
                  || (wr_idx == PWRIRQ_IDX_TIMER_EN) || (wr_idx == PWRIRQ_IDX_LINE_EN)
                  || (wr_idx == PWRIRQ_IDX_IND_EN) || (wr_idx == PWRIRQ_IDX_AUTO_PWR)
                  || (wr_idx == PWRIRQ_IDX_IND_REQ);
    wire wr_ok = wr_mapped && (awaddr_q[11:10] == 2'h0) && (awaddr_q[1:0] == 2'h0);

    // hold each channel once taken, release ready until the response goes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PWRIRQ_RESP_OKAY;
        end else begin
            // capture address
            if (aw_take) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end

            // capture data and strobes
            if (w_take) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end

            if (wr_fire) begin // one write at a time
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? PWRIRQ_RESP_OKAY : PWRIRQ_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // readies registered so outputs come from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // rise on the first edge after release
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            // drop on the take edge so nothing is captured twice
            s_axi_awready <= !aw_have_q && !aw_take && !s_axi_bvalid && !wr_fire;
            s_axi_wready <= !w_have_q && !w_take && !s_axi_bvalid && !wr_fire;
        end
    end

    // power override register, reserved bits held at zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // all three automatic after reset
            power_ovr_q <= PWRIRQ_POWER_OVR_RST;
        end else if (wr_hit_ovr) begin
            power_ovr_q <= wbyte & PWRIRQ_POWER_OVR_MASK;
        end
    end

    // per-block select: manual uses the on bit, auto uses the sequencer
    wire adc_man = power_ovr_q[PWRIRQ_ADC_MANUAL_BIT];
    wire dac_man = power_ovr_q[PWRIRQ_DAC_MANUAL_BIT];
    wire gm_man = power_ovr_q[PWRIRQ_TRANSAMP_MANUAL_BIT];
    wire adc_next = adc_man ? power_ovr_q[PWRIRQ_ADC_ON_BIT] : adc_auto_on;
    wire dac_next = dac_man ? power_ovr_q[PWRIRQ_DAC_ON_BIT] : dac_auto_on;
    wire gm_next = gm_man ? power_ovr_q[PWRIRQ_TRANSAMP_ON_BIT] : transamp_auto_on;

    // power outputs registered, one cycle behind the select
    // the cycle buys glitch-free controls to the analog blocks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // analog blocks off in reset
            adc_pwr <= 1'b0;
            dac_pwr <= 1'b0;
            transamp_pwr <= 1'b0;
        end else begin
            adc_pwr <= adc_next;
            dac_pwr <= dac_next;
            transamp_pwr <= gm_next;
        end
    end

    // indirect request: any lane-0 write to the request word starts one, done at tick
    wire ind_done = ind_busy_q && tick_hit;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ind_busy_q <= 1'b0;
            ind_req <= 1'b0;
        end else begin
            // a request while busy just keeps waiting
            if (wr_hit_req) begin
                ind_busy_q <= 1'b1;
            end else if (ind_done) begin
                ind_busy_q <= 1'b0;
            end
            // drops in the cycle the done bit rises
            ind_req <= wr_hit_req || (ind_busy_q && !ind_done);
        end
    end

    // pending sets: an event in the clear cycle wins over the clear
    wire [7:0] timer_set = {2'b00, timer_evt};
    wire [7:0] line_set = {alarm_evt, loop_change_evt, ring_trip_evt};
    wire [7:0] ind_set = {6'b000000, ind_done, 1'b0};
    wire [7:0] timer_clr = wr_hit_tp ? wbyte : 8'h00;
    wire [7:0] line_clr = wr_hit_lp ? wbyte : 8'h00;
    wire [7:0] ind_clr = wr_hit_ip ? wbyte : 8'h00;

    // reserved bits masked so they never set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // nothing pending
            timer_pend_q <= PWRIRQ_PEND_RST;
            line_pend_q <= PWRIRQ_PEND_RST;
            ind_pend_q <= PWRIRQ_PEND_RST;
        end else begin
            timer_pend_q <= ((timer_pend_q & ~timer_clr) | timer_set) & PWRIRQ_TIMER_MASK;
            line_pend_q <= ((line_pend_q & ~line_clr) | line_set) & PWRIRQ_LINE_MASK;
            ind_pend_q <= ((ind_pend_q & ~ind_clr) | ind_set) & PWRIRQ_IND_MASK;
        end
    end

    // enable registers; bits with no function are still read/write, except ind bits 7:2
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // all masked
            timer_en_q <= PWRIRQ_EN_RST;
            line_en_q <= PWRIRQ_EN_RST;
            ind_en_q <= PWRIRQ_EN_RST;
        end else begin
            if (wr_hit_te) begin
                timer_en_q <= wbyte;
            end
            if (wr_hit_le) begin
                line_en_q <= wbyte;
            end

            // only bits 1:0 kept
            if (wr_hit_ie) begin
                ind_en_q <= wbyte & PWRIRQ_IND_EN_MASK;
            end
        end
    end

    // interrupt: any pending bit with its enable set
    wire irq_next = |(timer_pend_q & timer_en_q & PWRIRQ_TIMER_MASK)
                  | |(line_pend_q & line_en_q)
                  | |(ind_pend_q & ind_en_q & PWRIRQ_IND_MASK);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // quiet in reset
            irq <= 1'b0;
        end else begin
            irq <= irq_next;
        end
    end

    // read path: mux on index, unmapped answers slverr with zero data
    wire [7:0] rd_idx = pwrirq_index(s_axi_araddr);
    wire rd_align = (s_axi_araddr[11:10] == 2'h0) && (s_axi_araddr[1:0] == 2'h0);

    // status words that are not registers
    wire [7:0] auto_stat = {5'b00000, adc_auto_on, dac_auto_on, transamp_auto_on};
    wire [7:0] req_stat = {7'b0000000, ind_busy_q};
    wire rd_hit;
    wire [7:0] rd_byte;

    // mapped places for the response code
    assign rd_hit = rd_align && ((rd_idx == PWRIRQ_IDX_POWER_OVR)
                  || (rd_idx == PWRIRQ_IDX_TIMER_PEND) || (rd_idx == PWRIRQ_IDX_LINE_PEND)
                  || (rd_idx == PWRIRQ_IDX_IND_PEND) || (rd_idx == PWRIRQ_IDX_TIMER_EN)
                  || (rd_idx == PWRIRQ_IDX_LINE_EN) || (rd_idx == PWRIRQ_IDX_IND_EN)
                  || (rd_idx == PWRIRQ_IDX_AUTO_PWR) || (rd_idx == PWRIRQ_IDX_IND_REQ));

    // data mux; unmapped reads give zero
    assign rd_byte = !rd_align ? 8'h00
                   : (rd_idx == PWRIRQ_IDX_POWER_OVR) ? power_ovr_q
                   : (rd_idx == PWRIRQ_IDX_TIMER_PEND) ? timer_pend_q
                   : (rd_idx == PWRIRQ_IDX_LINE_PEND) ? line_pend_q
                   : (rd_idx == PWRIRQ_IDX_IND_PEND) ? ind_pend_q
                   : (rd_idx == PWRIRQ_IDX_TIMER_EN) ? timer_en_q
                   : (rd_idx == PWRIRQ_IDX_LINE_EN) ? line_en_q
                   : (rd_idx == PWRIRQ_IDX_IND_EN) ? ind_en_q
                   : (rd_idx == PWRIRQ_IDX_AUTO_PWR) ? auto_stat
                   : (rd_idx == PWRIRQ_IDX_IND_REQ) ? req_stat
                   : 8'h00;
    // arready pulses for one cycle per accepted read
    wire ar_take = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= PWRIRQ_RESP_OKAY;
        end else begin
            // a read in flight holds arready low
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;

            // data and response captured on the take edge
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= rd_hit ? PWRIRQ_RESP_OKAY : PWRIRQ_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : pwrirq_regs
